// ---- charge_timer_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package charge_timer_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // Register offsets
    localparam logic [7:0] RESERVED_WORD_OFS      = 8'h0b;
    localparam logic [7:0] PRECHARGE_TIMER_OFS    = 8'h0d;
    localparam logic [7:0] SAFETY_TIMER_OFS       = 8'h0e;
    localparam logic [7:0] CHARGER_CONTROL_0_OFS  = 8'h0f;

    // Reset values
    localparam logic [15:0] RESERVED_WORD_VAL     = 16'h00dc;
    localparam logic [6:0]  PRECHARGE_RSVD_VAL    = 7'h4b;
    localparam logic [7:0]  SAFETY_TIMER_RST      = 8'h3d;
    localparam logic [7:0]  CHARGER_CONTROL_0_RST = 8'ha2;
    localparam logic        PRECHARGE_SEL_RST     = 1'b0;

    // Field positions, safety timer control
    localparam int unsigned TOPOFF_HI    = 7;
    localparam int unsigned TOPOFF_LO    = 6;
    localparam int unsigned TRICKLE_EN_B = 5;
    localparam int unsigned PRE_EN_B     = 4;
    localparam int unsigned FAST_EN_B    = 3;
    localparam int unsigned FAST_SEL_HI  = 2;
    localparam int unsigned FAST_SEL_LO  = 1;
    localparam int unsigned HALF_RATE_B  = 0;
    // Field positions, charger control 0, plus pre-charge select
    localparam int unsigned AUTO_DIS_B   = 7;
    localparam int unsigned FORCE_DIS_B  = 6;
    localparam int unsigned CHG_EN_B     = 5;
    localparam int unsigned ICO_EN_B     = 4;
    localparam int unsigned ICO_START_B  = 3;
    localparam int unsigned HIZ_B        = 2;
    localparam int unsigned TERM_EN_B    = 1;
    localparam int unsigned PRE_SEL_B    = 7;

    // Durations as printed, then in seconds
    localparam int unsigned TRICKLE_HRS       = 1;
    localparam int unsigned PRE_LONG_HRS      = 2;
    localparam int unsigned PRE_SHORT_MINS    = 30;
    localparam int unsigned FAST_HRS_0        = 5;
    localparam int unsigned FAST_HRS_1        = 8;
    localparam int unsigned FAST_HRS_2        = 12;
    localparam int unsigned FAST_HRS_3        = 24;
    localparam int unsigned TOPOFF_MINS_1     = 15;
    localparam int unsigned TOPOFF_MINS_2     = 30;
    localparam int unsigned TOPOFF_MINS_3     = 45;
    localparam int unsigned SEC_PER_MIN       = 60;
    localparam int unsigned SEC_PER_HR        = 3600;

    localparam int unsigned SEC_W = 17;

    // One timer second at the system clock rate
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_SECONDS  = 1;
    localparam int unsigned TICK_CYCLES   = TICK_SECONDS * CLK_HZ;

    typedef enum logic [2:0] {
        PHASE_IDLE    = 3'b000,
        PHASE_TRICKLE = 3'b001,
        PHASE_PRE     = 3'b011,
        PHASE_FAST    = 3'b010,
        PHASE_TOPOFF  = 3'b110
    } charge_phase_t;

    function automatic logic [SEC_W-1:0] secs_of_hours(input int unsigned hrs);
        secs_of_hours = SEC_W'(hrs * SEC_PER_HR);
    endfunction : secs_of_hours

    function automatic logic [SEC_W-1:0] secs_of_mins(input int unsigned mins);
        secs_of_mins = SEC_W'(mins * SEC_PER_MIN);
    endfunction : secs_of_mins

endpackage : charge_timer_pkg

// ---- charge_safety_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module charge_safety_timer
    import charge_timer_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic          sys_clk,         // System clock
    input  wire logic          srst,            // Sync reset, high
    input  wire logic          restart,         // Restart pulse
    input  wire charge_phase_t phase,           // Present charge phase
    input  wire logic          trickleEn,       // Trickle timer enable
    input  wire logic          preEn,           // Pre-charge timer enable
    input  wire logic          fastEn,          // Fast timer enable
    input  wire logic          preShort,        // Short pre-charge limit
    input  wire logic [1:0]    fastSel,         // Fast limit code
    input  wire logic [1:0]    topoffSel,       // Top-off limit code
    input  wire logic          halfRate,        // Half-rate request
    output logic               expired          // Limit reached
);

    logic [31:0]      tickCnt, next_tickCnt;
    logic             halfPhase, next_halfPhase;
    logic [SEC_W-1:0] secCnt, next_secCnt;
    charge_phase_t    lastPhase, next_lastPhase;
    logic             next_expired;
    logic             tick, advance, enabled, slow;
    logic [SEC_W-1:0] limit;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        limit   = '0;
        enabled = 1'b0;
        case (phase)
            PHASE_TRICKLE: begin
                enabled = trickleEn;
                limit   = secs_of_hours(TRICKLE_HRS);
            end
            PHASE_PRE: begin
                enabled = preEn;
                limit   = preShort ? secs_of_mins(PRE_SHORT_MINS)
                                   : secs_of_hours(PRE_LONG_HRS);
            end
            PHASE_FAST: begin
                enabled = fastEn;
                case (fastSel)
                    2'h0:    limit = secs_of_hours(FAST_HRS_0);
                    2'h1:    limit = secs_of_hours(FAST_HRS_1);
                    2'h2:    limit = secs_of_hours(FAST_HRS_2);
                    default: limit = secs_of_hours(FAST_HRS_3);
                endcase
            end
            PHASE_TOPOFF: begin
                enabled = (topoffSel != 2'h0);
                case (topoffSel)
                    2'h1:    limit = secs_of_mins(TOPOFF_MINS_1);
                    2'h2:    limit = secs_of_mins(TOPOFF_MINS_2);
                    default: limit = secs_of_mins(TOPOFF_MINS_3);
                endcase
            end
            default: begin
                enabled = 1'b0;
            end
        endcase
    end

    always_comb begin
        // Top-off is never stretched
        slow           = halfRate && (phase != PHASE_TOPOFF);
        tick           = (tickCnt == 32'(TICK_LEN - 1));
        next_tickCnt   = tick ? '0 : tickCnt + 32'h0000_0001;
        next_halfPhase = halfPhase;
        if (tick) begin
            next_halfPhase = slow ? ~halfPhase : 1'b0;
        end
        advance        = tick && (!slow || halfPhase);
        next_lastPhase = phase;
        next_secCnt    = secCnt;
        next_expired   = expired;
        if (restart || (phase != lastPhase)) begin
            next_secCnt  = '0;
            next_expired = 1'b0;
        end else if (enabled && !expired && advance) begin
            next_secCnt  = secCnt + SEC_W'(1);
            next_expired = (next_secCnt >= limit);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tickCnt   <= '0;
            halfPhase <= 1'b0;
            secCnt    <= '0;
            lastPhase <= PHASE_IDLE;
            expired   <= 1'b0;
        end else begin
            tickCnt   <= next_tickCnt;
            halfPhase <= next_halfPhase;
            secCnt    <= next_secCnt;
            lastPhase <= next_lastPhase;
            expired   <= next_expired;
        end
    end

endmodule : charge_safety_timer
`default_nettype wire

// ---- charge_timer_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module charge_timer_control_regs
    import charge_timer_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic              sys_clk,          // System clock
    input  wire logic              srst,             // Sync reset, high
    input  wire logic [ADDR_W-1:0] regAddr,          // Register offset
    input  wire logic              regWrite,         // Write strobe
    input  wire logic              regRead,          // Read strobe
    input  wire logic [DATA_W-1:0] regWdata,         // Write data
    output logic      [DATA_W-1:0] regRdata,         // Read data
    input  wire logic              watchdogExpired,  // Watchdog expiry pulse
    input  wire logic              regResetReq,      // Register reset pulse
    input  wire logic              adapterAttached,  // Adapter plug-in pulse
    input  wire logic              icoStarted,       // Optimizer started pulse
    input  wire logic              battOverVoltage,  // Battery OVERVOLTAGE_PROTECTION fault
    input  wire logic              dpmActive,        // Input DYNAMIC_POWER_MANAGEMENT active
    input  wire logic              thermalRegActive, // Thermal regulation
    input  wire charge_phase_t     chargePhase,      // Present charge phase
    output logic                   chargeAllowed,    // Charging permitted
    output logic                   terminationAllowed, // Termination permitted
    output logic                   highImpedance,    // HIZ mode
    output logic                   optimizerOn,      // Optimizer enabled
    output logic                   optimizerStart,   // Optimizer start request
    output logic                   battDischarge,    // Discharge current on
    output logic                   safetyTimerExpired // Timer limit reached
);

    logic       preSel, next_preSel;
    logic [7:0] timerCtl, next_timerCtl;
    logic [7:0] chgCtl, next_chgCtl;
    logic [DATA_W-1:0] next_regRdata;
    logic       next_battDischarge;
    logic       wrPre, wrTimer, wrChg, timerRestart;

    //////////////////////////////////////////////////////////////////////////
    // Register writes and hardware updates
    always_comb begin
        wrPre   = regWrite && (regAddr == PRECHARGE_TIMER_OFS);
        wrTimer = regWrite && (regAddr == SAFETY_TIMER_OFS);
        wrChg   = regWrite && (regAddr == CHARGER_CONTROL_0_OFS);

        next_preSel   = preSel;
        next_timerCtl = timerCtl;
        next_chgCtl   = chgCtl;

        // Device-side clears first so a same-cycle write still lands
        if (icoStarted) begin
            next_chgCtl[ICO_START_B] = 1'b0;
        end
        if (adapterAttached) begin
            next_chgCtl[HIZ_B] = 1'b0;
        end

        if (wrPre) begin
            next_preSel = regWdata[PRE_SEL_B];
        end
        if (wrTimer) begin
            next_timerCtl = regWdata[7:0];
        end
        if (wrChg) begin
            next_chgCtl[AUTO_DIS_B]  = regWdata[AUTO_DIS_B];
            next_chgCtl[FORCE_DIS_B] = regWdata[FORCE_DIS_B];
            next_chgCtl[CHG_EN_B]    = regWdata[CHG_EN_B];
            next_chgCtl[ICO_EN_B]    = regWdata[ICO_EN_B];
            next_chgCtl[HIZ_B]       = regWdata[HIZ_B];
            next_chgCtl[TERM_EN_B]   = regWdata[TERM_EN_B];
            // Writing zero cannot cancel a pending start
            if (regWdata[ICO_START_B] && regWdata[ICO_EN_B]) begin
                next_chgCtl[ICO_START_B] = 1'b1;
            end
        end
        // Disabling the optimizer drops any pending start
        if (!next_chgCtl[ICO_EN_B]) begin
            next_chgCtl[ICO_START_B] = 1'b0;
        end

        if (watchdogExpired) begin
            next_preSel               = PRECHARGE_SEL_RST;
            next_timerCtl             = SAFETY_TIMER_RST;
            next_chgCtl[CHG_EN_B]     = CHARGER_CONTROL_0_RST[CHG_EN_B];
            next_chgCtl[ICO_START_B]  = CHARGER_CONTROL_0_RST[ICO_START_B];
            next_chgCtl[TERM_EN_B]    = CHARGER_CONTROL_0_RST[TERM_EN_B];
        end
        if (regResetReq) begin
            next_preSel   = PRECHARGE_SEL_RST;
            next_timerCtl = SAFETY_TIMER_RST;
            next_chgCtl   = CHARGER_CONTROL_0_RST;
        end
        next_chgCtl[0] = 1'b0;

        timerRestart = regResetReq;

        next_battDischarge = next_chgCtl[FORCE_DIS_B]
                          || (next_chgCtl[AUTO_DIS_B] && battOverVoltage);
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path; unmapped offsets return zero
    always_comb begin
        next_regRdata = regRdata;
        if (regRead) begin
            if (regAddr == RESERVED_WORD_OFS) begin
                next_regRdata = RESERVED_WORD_VAL;
            end else if (regAddr == PRECHARGE_TIMER_OFS) begin
                next_regRdata = {8'h00, preSel, PRECHARGE_RSVD_VAL};
            end else if (regAddr == SAFETY_TIMER_OFS) begin
                next_regRdata = {8'h00, timerCtl};
            end else if (regAddr == CHARGER_CONTROL_0_OFS) begin
                next_regRdata = {8'h00, chgCtl};
            end else begin
                next_regRdata = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            preSel        <= PRECHARGE_SEL_RST;
            timerCtl      <= SAFETY_TIMER_RST;
            chgCtl        <= CHARGER_CONTROL_0_RST;
            regRdata      <= '0;
            battDischarge <= 1'b0;
        end else begin
            preSel        <= next_preSel;
            timerCtl      <= next_timerCtl;
            chgCtl        <= next_chgCtl;
            regRdata      <= next_regRdata;
            battDischarge <= next_battDischarge;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control outputs straight from register bits
    always_comb begin
        chargeAllowed      = chgCtl[CHG_EN_B];
        terminationAllowed = chgCtl[TERM_EN_B];
        highImpedance      = chgCtl[HIZ_B];
        optimizerOn        = chgCtl[ICO_EN_B];
        optimizerStart     = chgCtl[ICO_START_B];
    end

    //////////////////////////////////////////////////////////////////////////
    charge_safety_timer #(
        .TICK_LEN (TICK_LEN)
    ) u_timer (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .restart   (timerRestart),
        .phase     (chargePhase),
        .trickleEn (timerCtl[TRICKLE_EN_B]),
        .preEn     (timerCtl[PRE_EN_B]),
        .fastEn    (timerCtl[FAST_EN_B]),
        .preShort  (preSel),
        .fastSel   (timerCtl[FAST_SEL_HI:FAST_SEL_LO]),
        .topoffSel (timerCtl[TOPOFF_HI:TOPOFF_LO]),
        .halfRate  (timerCtl[HALF_RATE_B] && (dpmActive || thermalRegActive)),
        .expired   (safetyTimerExpired)
    );

endmodule : charge_timer_control_regs
`default_nettype wire

// ---- charge_timer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module charge_timer_monitor
    import charge_timer_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic              sys_clk,            // Clock
    input  wire logic              srst,               // Reset
    input  wire logic [ADDR_W-1:0] regAddr,            // Offset
    input  wire logic              regWrite,           // Write strobe
    input  wire logic [DATA_W-1:0] regWdata,           // Write data
    input  wire logic              watchdogExpired,    // Watchdog
    input  wire logic              regResetReq,        // Register reset
    input  wire logic              adapterAttached,    // Adapter
    input  wire logic              icoStarted,         // Start seen
    input  wire logic              chargeAllowed,      // Charge
    input  wire logic              terminationAllowed, // Termination
    input  wire logic              highImpedance,      // High impedance
    input  wire logic              optimizerOn,        // Optimizer
    input  wire logic              optimizerStart,     // Start request
    input  wire logic              battDischarge       // Discharge
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_ctl_write(dis);
        regWrite && regAddr == CHARGER_CONTROL_0_OFS && regWdata[7:6] == dis && !regResetReq;
    endsequence
    sequence s_quiet;
        !regWrite && !regResetReq;
    endsequence
    AST_RST_VALUES: assert property ($fell(srst) |-> chargeAllowed && terminationAllowed
        && !highImpedance && !optimizerOn && !optimizerStart) else $error("bad reset value");
    AST_WRITE_CHG: assert property (s_ctl_write(regWdata[7:6]) and !watchdogExpired
        |=> chargeAllowed == $past(regWdata[5]) && terminationAllowed == $past(regWdata[1]))
        else $error("control write lost");
    AST_HIGHZ_CLEAR: assert property (adapterAttached && !regWrite && !regResetReq
        |=> !highImpedance) else $error("high impedance kept");
    AST_START_CLEAR: assert property (icoStarted && !regWrite && !regResetReq
        |=> !optimizerStart) else $error("start kept");
    AST_START_NEEDS_EN: assert property (optimizerStart |-> optimizerOn)
        else $error("start without enable");
    AST_START_SET: assert property ($rose(optimizerStart) |-> $past(regWrite)
        && $past(regAddr) == CHARGER_CONTROL_0_OFS && $past(regWdata[4:3]) == 2'b11)
        else $error("start set without write");
    AST_WDOG: assert property (watchdogExpired && !regResetReq |=> chargeAllowed
        && terminationAllowed && !optimizerStart) else $error("watchdog reset missing");
    AST_WDOG_KEEPS: assert property (watchdogExpired and s_quiet and !adapterAttached
        |=> $stable(highImpedance) && $stable(optimizerOn)) else $error("watchdog cleared kept bit");
    AST_REGRST: assert property (regResetReq |=> chargeAllowed && terminationAllowed
        && !highImpedance && !optimizerOn && !optimizerStart) else $error("register reset missing");
    AST_FORCE: assert property (s_ctl_write(2'b01) ##1 s_quiet |=> battDischarge)
        else $error("forced discharge missing");
    AST_AUTO_OFF: assert property (s_ctl_write(2'b00) ##1 s_quiet |=> !battDischarge)
        else $error("discharge while disabled");
endmodule : charge_timer_monitor
`default_nettype wire

// ---- host_access_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_access_model
    import charge_timer_pkg::*;
(
    input  wire logic              sys_clk,  // Clock
    output logic      [ADDR_W-1:0] regAddr,  // Offset
    output logic                   regWrite, // Write strobe
    output logic                   regRead,  // Read strobe
    output logic      [DATA_W-1:0] regWdata, // Write data
    input  wire logic [DATA_W-1:0] regRdata  // Read data
);
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 16'h0000;
    end
    // Released lines flip so a stale value is never mistaken for a driven one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
        regWdata = ~d;
        regAddr = ~a;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        regAddr = ~a;
        @(negedge sys_clk);
        d = regRdata;
    endtask : rd
endmodule : host_access_model
`default_nettype wire

// ---- tb_charge_timer_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_charge_timer_control_regs;
    import charge_timer_pkg::*;
    localparam int unsigned TL = 4;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr;
    logic regWrite, regRead;
    logic [15:0] regWdata, regRdata, rv;
    logic watchdogExpired = 0, regResetReq = 0, adapterAttached = 0, icoStarted = 0;
    logic battOverVoltage = 0, dpmActive = 0, thermalRegActive = 0;
    charge_phase_t chargePhase = PHASE_IDLE;
    logic chargeAllowed, terminationAllowed, highImpedance, optimizerOn, optimizerStart;
    logic battDischarge, safetyTimerExpired;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    charge_timer_control_regs #(.TICK_LEN(TL)) dut_u (.sys_clk(sys_clk), .srst(srst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .watchdogExpired(watchdogExpired), .regResetReq(regResetReq),
        .adapterAttached(adapterAttached), .icoStarted(icoStarted),
        .battOverVoltage(battOverVoltage), .dpmActive(dpmActive),
        .thermalRegActive(thermalRegActive), .chargePhase(chargePhase),
        .chargeAllowed(chargeAllowed), .terminationAllowed(terminationAllowed),
        .highImpedance(highImpedance), .optimizerOn(optimizerOn),
        .optimizerStart(optimizerStart), .battDischarge(battDischarge),
        .safetyTimerExpired(safetyTimerExpired));
    host_access_model host_u (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Timer tests dominate the run, about 62000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        host_u.rd(a, rv);
        chk_word($sformatf("register %h", a), e, rv);
    endtask : rchk
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    task automatic settle_bit(input string n, input logic e);
        repeat (2) @(negedge sys_clk);
        chk_bit(n, e, battDischarge);
    endtask : settle_bit
    // Leaving idle first restarts the count for every phase
    task automatic tmr(input charge_phase_t p, input int secs);
        @(negedge sys_clk);
        chargePhase = PHASE_IDLE;
        repeat (4) @(negedge sys_clk);
        chargePhase = p;
        repeat ((secs - 8) * TL) @(negedge sys_clk);
        chk_bit("timer early", 1'b0, safetyTimerExpired);
        repeat (16 * TL) @(negedge sys_clk);
        chk_bit("timer expiry", 1'b1, safetyTimerExpired);
    endtask : tmr
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        rchk(8'h0b, 16'h00dc);
        rchk(8'h0d, 16'h004b);
        rchk(8'h0e, 16'h003d);
        rchk(8'h0f, 16'h00a2);
        rchk(8'h0c, 16'h0000);
        $display("test reset values done");
        host_u.wr(8'h0b, 16'hffff);
        rchk(8'h0b, 16'h00dc);
        host_u.wr(8'h0d, 16'hffff);
        rchk(8'h0d, 16'h00cb);
        host_u.wr(8'h0e, 16'h00c2);
        rchk(8'h0e, 16'h00c2);
        host_u.wr(8'h0f, 16'h00ff);
        rchk(8'h0f, 16'h00fe);
        chk_bit("highImpedance", 1'b1, highImpedance);
        chk_bit("optimizerOn", 1'b1, optimizerOn);
        chk_bit("optimizerStart", 1'b1, optimizerStart);
        chk_bit("terminationAllowed", 1'b1, terminationAllowed);
        pulse(adapterAttached);
        pulse(icoStarted);
        rchk(8'h0f, 16'h00f2);
        host_u.wr(8'h0f, 16'h0008);
        rchk(8'h0f, 16'h0000);
        chk_bit("chargeAllowed", 1'b0, chargeAllowed);
        $display("test access done");
        host_u.wr(8'h0e, 16'h0000);
        host_u.wr(8'h0d, 16'h0080);
        host_u.wr(8'h0f, 16'h005c);
        pulse(watchdogExpired);
        rchk(8'h0d, 16'h004b);
        rchk(8'h0e, 16'h003d);
        rchk(8'h0f, 16'h0076);
        pulse(regResetReq);
        rchk(8'h0f, 16'h00a2);
        $display("test watchdog and reset done");
        @(negedge sys_clk);
        battOverVoltage = 1'b1;
        settle_bit("auto discharge", 1'b1);
        host_u.wr(8'h0f, 16'h0022);
        settle_bit("auto disabled", 1'b0);
        host_u.wr(8'h0f, 16'h0062);
        battOverVoltage = 1'b0;
        settle_bit("forced discharge", 1'b1);
        pulse(regResetReq);
        settle_bit("discharge idle", 1'b0);
        $display("test discharge done");
        tmr(PHASE_TRICKLE, TRICKLE_HRS * SEC_PER_HR);
        dpmActive = 1'b1;
        tmr(PHASE_TRICKLE, 2 * TRICKLE_HRS * SEC_PER_HR);
        dpmActive = 1'b0;
        host_u.wr(8'h0d, 16'h0080);
        tmr(PHASE_PRE, PRE_SHORT_MINS * SEC_PER_MIN);
        thermalRegActive = 1'b1;
        host_u.wr(8'h0e, 16'h007d);
        tmr(PHASE_TOPOFF, TOPOFF_MINS_1 * SEC_PER_MIN);
        thermalRegActive = 1'b0;
        // Pre-charge timer off: a full short limit passes with no expiry
        host_u.wr(8'h0e, 16'h002d);
        chargePhase = PHASE_IDLE;
        repeat (4) @(negedge sys_clk);
        chargePhase = PHASE_PRE;
        repeat ((PRE_SHORT_MINS * SEC_PER_MIN + 16) * TL) @(negedge sys_clk);
        chk_bit("pre timer disabled", 1'b0, safetyTimerExpired);
        $display("test timers done");
        report_and_stop();
    end
endmodule : tb_charge_timer_control_regs
bind charge_timer_control_regs charge_timer_monitor #(.TICK_LEN(TICK_LEN)) mon_u (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .watchdogExpired(watchdogExpired), .regResetReq(regResetReq),
    .adapterAttached(adapterAttached), .icoStarted(icoStarted),
    .chargeAllowed(chargeAllowed), .terminationAllowed(terminationAllowed),
    .highImpedance(highImpedance), .optimizerOn(optimizerOn),
    .optimizerStart(optimizerStart), .battDischarge(battDischarge));
`default_nettype wire
